//--- verilog/frm_regs.svh
// Summary of operation
// [R1] Controller pulses primary and mailbox-2 resets low together after power-up.
// [R2] Full reset needs four port A and four port B clock rises.
// [R3] Full reset inputs may change at any time, unrelated to port clocks.
// [R4] Full reset clears pointers; ready flags low, almost-empty low, almost-full high.
// [R5] Primary reset forces mailbox-1 flag high; mailbox-2 reset forces mailbox-2 high.
// [R6] Input-ready rises two port A clocks after reset ends.
// [R7] Primary reset rise captures the endian choice for port B.
// [R8] Primary reset rise captures flag selects and serial mode for offset loading.
// [R9] Partial reset clears pointers, sets flags like full reset, both mail high.
// [R10] Partial reset input may change at any time, unrelated to port clocks.
// [R11] Partial reset keeps offsets, programming method and timing mode.
// [R12] Big endian: most significant part of each long word leaves first.
// [R13] Little endian: least significant part of each long word leaves first.
// [R14] Endian choice ignored when port B uses full long-word width.
// [R15] Next port clock rise after reset picks standard (high) or fall-through.
// [R16] Standard mode: empty/full flags, every word needs an explicit read.
// [R17] Fall-through: first word appears without read, output-ready marks it.
// [R18] Controller holds the timing select level steady during operation.
// [R19] Two offset registers, loaded from presets, port A writes, or serially.
// [R20] Serial mode high with a flag select high loads presets; both high gives 64.
// [R21] Parallel method: first two port A writes load almost-full then almost-empty.
// [R22] Parallel method: third port A write onward goes into the memory.
// [R23] Serial method: serial mode low, data low, enable high at reset rise.
// [R24] Serial: one bit per port A rise with enable low, almost-full first, 20 bits.
// [R25] Serial: input-ready stays low until last bit, rises on next port A rise.
`ifndef FRM_REGS_SVH
`define FRM_REGS_SVH
// APB byte offsets
`define FRM_OFS_CTRL    12'h000
`define FRM_OFS_STATUS  12'h004
`define FRM_OFS_OFFSETS 12'h008
`define FRM_OFS_PTRS    12'h00c
// Port B width codes and reset value
`define FRM_WIDTH_LONG  2'h0
`define FRM_WIDTH_WORD  2'h1
`define FRM_WIDTH_BYTE  2'h2
`define FRM_CTRL_RESET  2'h0
// Sequencing counts
`define FRM_RST_EDGES   3'h4
`define FRM_IR_DELAY    2'h2
`define FRM_SER_BITS    5'h14
`define FRM_PAR_WORDS   2'h2
`define FRM_DEPTH       11'h400
// Preset offsets
`define FRM_PRESET_64   10'h040
`define FRM_PRESET_16   10'h010
`define FRM_PRESET_8    10'h008
`endif

//--- verilog/frm_pkg.sv
package frm_pkg;
    typedef enum logic [1:0] {
        FRM_PRESET   = 2'b00,
        FRM_PARALLEL = 2'b01,
        FRM_SERIAL   = 2'b10,
        FRM_RESERVED = 2'b11
    } frm_prog_e;

    typedef struct packed {
        logic        pa_q;
        logic        pb_q;
        logic        prim_q;
        logic        rst_q;
        logic [2:0]  cnt_a;
        logic [2:0]  cnt_b;
        logic        short_rst;
        logic        be_cap;
        frm_prog_e   prog;
        logic        ft_mode;
        logic        mode_pend;
        logic [1:0]  ir_cnt;
        logic        fir;
        logic        eor;
        logic        ae_n;
        logic        af_n;
        logic [9:0]  x_off;
        logic [9:0]  y_off;
        logic [1:0]  pcount;
        logic [4:0]  ser_cnt;
        logic [19:0] ser_sh;
        logic [10:0] wr_ptr;
        logic [10:0] rd_ptr;
        logic        mb1_n;
        logic        mb2_n;
        logic        load_b;
        logic [1:0]  width;
    } frm_state_s;
endpackage

//--- verilog/frm_reset_cfg.sv
`timescale 1ns/1ps
`include "frm_regs.svh"

module frm_reset_cfg
    import frm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_a_clock,
    input  wire logic        port_b_clock,
    input  wire logic        primary_reset_n,
    input  wire logic        mailbox2_reset_n,
    input  wire logic        partial_reset_n,
    input  wire logic        endian_timing_select,
    input  wire logic        serial_program_mode_n,
    input  wire logic        flag_sel0_serial_data,
    input  wire logic        flag_sel1_serial_enable_n,
    input  wire logic        write_a,
    input  wire logic [9:0]  data_a,
    input  wire logic        read_b,
    input  wire logic        mail1_write_a,
    input  wire logic        mail1_read_b,
    input  wire logic        mail2_write_b,
    input  wire logic        mail2_read_a,
    output logic             full_input_ready,
    output logic             empty_output_ready,
    output logic             almost_empty_n,
    output logic             almost_full_n,
    output logic             mail1_full_n,
    output logic             mail2_full_n,
    output logic             fall_through_mode,
    output logic             big_endian_b,
    output logic             load_b
);
    frm_state_s  s_reg;
    frm_state_s  s_next;
    logic        a_edge;
    logic        b_edge;
    logic        rstok;
    logic        prim_rise;
    logic        apb_acc;
    logic        apb_hit;
    logic [10:0] cnt;
    logic [10:0] cnt_a_side;
    logic [10:0] cnt_b_side;
    logic [19:0] sh_new;

    // Edge detects on port clocks, sampled as ordinary inputs
    assign a_edge    = port_a_clock & ~s_reg.pa_q;
    assign b_edge    = port_b_clock & ~s_reg.pb_q;
    assign rstok     = primary_reset_n & partial_reset_n;
    assign prim_rise = primary_reset_n & ~s_reg.prim_q;
    assign cnt       = s_reg.wr_ptr - s_reg.rd_ptr;

    // APB slave: no wait states, error on unmapped offsets
    assign apb_acc = psel & penable;
    assign apb_hit = (paddr == `FRM_OFS_CTRL) || (paddr == `FRM_OFS_STATUS)
                  || (paddr == `FRM_OFS_OFFSETS) || (paddr == `FRM_OFS_PTRS);
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~apb_hit;

    // Read data mux over the state flops
    always_comb begin
        prdata = 32'h0;
        case (paddr)
            `FRM_OFS_CTRL: begin
                prdata[1:0] = s_reg.width;
            end
            `FRM_OFS_STATUS: begin
                prdata[11:0] = {s_reg.mb2_n, s_reg.mb1_n, s_reg.mode_pend,
                                s_reg.short_rst, s_reg.prog, s_reg.be_cap,
                                s_reg.ft_mode, s_reg.af_n, s_reg.ae_n,
                                s_reg.eor, s_reg.fir};
            end
            `FRM_OFS_OFFSETS: begin
                prdata = {6'h0, s_reg.y_off, 6'h0, s_reg.x_off};
            end
            `FRM_OFS_PTRS: begin
                prdata = {5'h0, s_reg.rd_ptr, 5'h0, s_reg.wr_ptr};
            end
            default: begin
                prdata = 32'h0;
            end
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        s_next        = s_reg;
        s_next.pa_q   = port_a_clock;
        s_next.pb_q   = port_b_clock;
        s_next.prim_q = primary_reset_n;
        s_next.rst_q  = rstok;
        s_next.load_b = 1'b0;
        sh_new        = {s_reg.ser_sh[18:0], flag_sel0_serial_data};
        cnt_a_side    = cnt;
        cnt_b_side    = cnt;

        // Port B width control
        if (apb_acc && pwrite && paddr == `FRM_OFS_CTRL) begin
            s_next.width = pwdata[1:0];
        end

        // Configuration latched on primary reset rise
        if (prim_rise) begin
            s_next.be_cap    = endian_timing_select;  // R7
            s_next.mode_pend = 1'b1;
            s_next.pcount    = 2'h0;
            s_next.ser_cnt   = 5'h0;
            s_next.ser_sh    = 20'h0;
            if (serial_program_mode_n) begin  // R8
                case ({flag_sel1_serial_enable_n, flag_sel0_serial_data})
                    2'b11: begin
                        s_next.prog  = FRM_PRESET;  // R20
                        s_next.x_off = `FRM_PRESET_64;
                        s_next.y_off = `FRM_PRESET_64;
                    end
                    2'b10: begin
                        s_next.prog  = FRM_PRESET;
                        s_next.x_off = `FRM_PRESET_16;
                        s_next.y_off = `FRM_PRESET_16;
                    end
                    2'b01: begin
                        s_next.prog  = FRM_PRESET;
                        s_next.x_off = `FRM_PRESET_8;
                        s_next.y_off = `FRM_PRESET_8;
                    end
                    default: begin
                        s_next.prog = FRM_PARALLEL;  // R21
                    end
                endcase
            end else if (flag_sel1_serial_enable_n && !flag_sel0_serial_data) begin
                s_next.prog = FRM_SERIAL;  // R23
            end else begin
                s_next.prog = FRM_RESERVED;
            end
        end

        // Timing mode picked at the first port A clock rise after release
        if (s_reg.mode_pend && primary_reset_n && !prim_rise && a_edge) begin
            s_next.ft_mode   = ~endian_timing_select;  // R15
            s_next.mode_pend = 1'b0;
        end

        if (!rstok) begin
            // Reset held: clear pointers, force flags, count port clock rises
            s_next.wr_ptr = 11'h0;  // R4 R9
            s_next.rd_ptr = 11'h0;
            s_next.fir    = 1'b0;
            s_next.eor    = 1'b0;
            s_next.ae_n   = 1'b0;
            s_next.af_n   = 1'b1;
            s_next.ir_cnt = 2'h0;
            if (a_edge && s_reg.cnt_a != `FRM_RST_EDGES) begin
                s_next.cnt_a = s_reg.cnt_a + 3'h1;  // R2
            end
            if (b_edge && s_reg.cnt_b != `FRM_RST_EDGES) begin
                s_next.cnt_b = s_reg.cnt_b + 3'h1;
            end
        end else if (!s_reg.rst_q) begin
            // First cycle after release: note an undersized reset
            s_next.short_rst = (s_reg.cnt_a != `FRM_RST_EDGES)
                            || (s_reg.cnt_b != `FRM_RST_EDGES);
            s_next.cnt_a = 3'h0;
            s_next.cnt_b = 3'h0;
        end else begin
            // Port A side: ready delay, serial load, writes, full flags
            if (a_edge) begin
                if (s_reg.ir_cnt != `FRM_IR_DELAY) begin
                    s_next.ir_cnt = s_reg.ir_cnt + 2'h1;  // R6
                end
                if (s_reg.prog == FRM_SERIAL && s_reg.ser_cnt != `FRM_SER_BITS
                    && !flag_sel1_serial_enable_n) begin
                    s_next.ser_sh  = sh_new;  // R24
                    s_next.ser_cnt = s_reg.ser_cnt + 5'h1;
                    if (s_reg.ser_cnt == `FRM_SER_BITS - 5'h1) begin
                        s_next.y_off = sh_new[19:10];
                        s_next.x_off = sh_new[9:0];
                    end
                end
                if (write_a && s_reg.fir) begin
                    if (s_reg.prog == FRM_PARALLEL && s_reg.pcount != `FRM_PAR_WORDS) begin
                        if (s_reg.pcount == 2'h0) begin
                            s_next.y_off = data_a;  // R21
                        end else begin
                            s_next.x_off = data_a;
                        end
                        s_next.pcount = s_reg.pcount + 2'h1;
                    end else begin
                        s_next.wr_ptr = s_reg.wr_ptr + 11'h1;  // R22
                    end
                end
                cnt_a_side  = s_next.wr_ptr - s_reg.rd_ptr;
                s_next.fir  = (s_next.ir_cnt == `FRM_IR_DELAY)  // R6 R9
                           && (s_reg.prog != FRM_SERIAL
                               || s_reg.ser_cnt == `FRM_SER_BITS)  // R25
                           && (cnt_a_side != `FRM_DEPTH);  // R16
                s_next.af_n = (`FRM_DEPTH - cnt_a_side) > {1'b0, s_reg.y_off};
            end
            // Port B side: output register and empty flags
            if (b_edge) begin
                if (s_reg.ft_mode) begin
                    if (!s_reg.eor || read_b) begin
                        if (cnt != 11'h0) begin
                            s_next.rd_ptr = s_reg.rd_ptr + 11'h1;  // R17
                            s_next.eor    = 1'b1;
                            s_next.load_b = 1'b1;
                        end else begin
                            s_next.eor = 1'b0;
                        end
                    end
                end else begin
                    if (read_b && s_reg.eor) begin
                        s_next.rd_ptr = s_reg.rd_ptr + 11'h1;  // R16
                        s_next.load_b = 1'b1;
                    end
                    s_next.eor = (s_reg.wr_ptr - s_next.rd_ptr) != 11'h0;
                end
                cnt_b_side  = s_reg.wr_ptr - s_next.rd_ptr;
                s_next.ae_n = cnt_b_side > {1'b0, s_reg.x_off};
            end
        end

        // Mailbox flags: writes clear, reads set, resets force high
        if (a_edge && mail1_write_a) begin
            s_next.mb1_n = 1'b0;
        end
        if (b_edge && mail1_read_b) begin
            s_next.mb1_n = 1'b1;
        end
        if (b_edge && mail2_write_b) begin
            s_next.mb2_n = 1'b0;
        end
        if (a_edge && mail2_read_a) begin
            s_next.mb2_n = 1'b1;
        end
        if (!rstok) begin
            s_next.mb1_n = 1'b1;  // R5 R9
        end
        if (!mailbox2_reset_n || !partial_reset_n) begin
            s_next.mb2_n = 1'b1;  // R5 R9
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg           <= '0;
            s_reg.prim_q    <= 1'b1;
            s_reg.rst_q     <= 1'b1;
            s_reg.af_n      <= 1'b1;
            s_reg.mb1_n     <= 1'b1;
            s_reg.mb2_n     <= 1'b1;
            s_reg.prog      <= FRM_PRESET;
            s_reg.x_off     <= `FRM_PRESET_64;
            s_reg.y_off     <= `FRM_PRESET_64;
            s_reg.width     <= `FRM_CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Flag pins: reset levels forced without waiting for a clock
    assign full_input_ready   = s_reg.fir & rstok;  // R3 R10
    assign empty_output_ready = s_reg.eor & rstok;
    assign almost_empty_n     = s_reg.ae_n & rstok;
    assign almost_full_n      = s_reg.af_n | ~rstok;
    assign mail1_full_n       = s_reg.mb1_n | ~rstok;
    assign mail2_full_n       = s_reg.mb2_n | ~mailbox2_reset_n | ~partial_reset_n;
    assign fall_through_mode  = s_reg.ft_mode;
    // Byte order only matters for narrow port B
    assign big_endian_b       = s_reg.be_cap & (s_reg.width != `FRM_WIDTH_LONG);  // R12 R13 R14
    assign load_b             = s_reg.load_b;

    // Checks
    AST_RST_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)  // R4
        !rstok |-> !full_input_ready && !empty_output_ready
                   && !almost_empty_n && almost_full_n)
        else $error("reset flag levels wrong");

    AST_MAIL_FORCE: assert property (@(posedge pclk) disable iff (!presetn)  // R5
        (!primary_reset_n |-> mail1_full_n) and (!mailbox2_reset_n |-> mail2_full_n))
        else $error("mailbox flag not forced high");

    AST_IR_DELAY: assert property (@(posedge pclk) disable iff (!presetn)  // R6
        rstok && !s_reg.rst_q |-> !full_input_ready [*2])
        else $error("input ready rose too soon");

    AST_BE_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)  // R7
        prim_rise |=> s_reg.be_cap == $past(endian_timing_select))
        else $error("endian not captured");

    AST_PRESET64: assert property (@(posedge pclk) disable iff (!presetn)  // R20
        prim_rise && serial_program_mode_n && flag_sel0_serial_data
        && flag_sel1_serial_enable_n |=> s_reg.x_off == `FRM_PRESET_64
        && s_reg.y_off == `FRM_PRESET_64 && s_reg.prog == FRM_PRESET)
        else $error("preset 64 not loaded");

    AST_PARTIAL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)  // R11
        !partial_reset_n && primary_reset_n && s_reg.prim_q && !s_reg.mode_pend
        |=> $stable(s_reg.x_off) && $stable(s_reg.y_off)
            && $stable(s_reg.prog) && $stable(s_reg.ft_mode))
        else $error("partial reset changed configuration");

    AST_SER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)  // R25
        s_reg.prog == FRM_SERIAL && s_reg.ser_cnt != `FRM_SER_BITS
        |-> !full_input_ready)
        else $error("input ready during serial load");

    AST_ENDIAN_LONG: assert property (@(posedge pclk) disable iff (!presetn)  // R14
        s_reg.width == `FRM_WIDTH_LONG |-> !big_endian_b)
        else $error("endian applied to long word");

    AST_PAR_FIRST: assert property (@(posedge pclk) disable iff (!presetn)  // R21
        rstok && s_reg.rst_q && a_edge && write_a && s_reg.fir
        && s_reg.prog == FRM_PARALLEL && s_reg.pcount == 2'h0
        |=> s_reg.y_off == $past(data_a) && $stable(s_reg.wr_ptr))
        else $error("first parallel write not to almost-full offset");
endmodule

//--- verification/frm_far_end.sv
`timescale 1ns/1ps

// Far-end controller with free-running port clocks and write/read strobes
module frm_far_end (
    input  wire logic pclk,
    input  wire logic wr_req,
    input  wire logic rd_req,
    output logic      port_a_clock,
    output logic      port_b_clock,
    output logic      write_a,
    output logic      read_b
);
    logic [1:0] div_a = 2'h0;
    logic [2:0] div_b = 3'h0;
    logic       wa    = 1'b0;
    logic       rb    = 1'b0;

    // Port A period is 4 pclk and port B period is 6 pclk, so the edges drift apart
    assign port_a_clock = div_a[1];
    assign port_b_clock = (div_b >= 3'h3);
    assign write_a      = wa;
    assign read_b       = rb;

    // Strobes change only as their port clock falls, so they stand across the rise
    always @(posedge pclk) begin
        div_a <= div_a + 2'h1;
        div_b <= (div_b == 3'h5) ? 3'h0 : div_b + 3'h1;
        if (div_a == 2'h3) wa <= wr_req;
        if (div_b == 3'h5) rb <= rd_req;
    end
endmodule

//--- verification/fifo_reset_mode_config_test.sv
`timescale 1ns/1ps
`include "frm_regs.svh"

module fifo_reset_mode_config_test;
    typedef struct packed {
        logic [3:0] cfg;
        logic [1:0] prog;
        logic       fir;
        logic [9:0] off;
    } frm_row_s;
    localparam logic [19:0] ser_word = 20'h3cd2c;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        primary_reset_n, mailbox2_reset_n, partial_reset_n, endian_timing_select;
    logic        serial_program_mode_n, flag_sel0_serial_data, flag_sel1_serial_enable_n;
    logic        port_a_clock, port_b_clock, write_a, read_b, wr_req, rd_req;
    logic        mail1_write_a, mail1_read_b, mail2_write_b, mail2_read_a;
    logic [9:0]  data_a;
    logic        full_input_ready, empty_output_ready, almost_empty_n, almost_full_n;
    logic        mail1_full_n, mail2_full_n, fall_through_mode, big_endian_b, load_b;
    logic [5:0]  flg;
    int          error_cnt, samples_checked, cycles;
    frm_row_s    rows [5];

    frm_far_end i_frm_far_end (.pclk, .wr_req, .rd_req, .port_a_clock, .port_b_clock,
        .write_a, .read_b);
    frm_reset_cfg i_frm_reset_cfg (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .port_a_clock, .port_b_clock, .primary_reset_n,
        .mailbox2_reset_n, .partial_reset_n, .endian_timing_select, .serial_program_mode_n,
        .flag_sel0_serial_data, .flag_sel1_serial_enable_n, .write_a, .data_a, .read_b,
        .mail1_write_a, .mail1_read_b, .mail2_write_b, .mail2_read_a, .full_input_ready,
        .empty_output_ready, .almost_empty_n, .almost_full_n, .mail1_full_n, .mail2_full_n,
        .fall_through_mode, .big_endian_b, .load_b);

    // Ready, output-ready, almost-empty, almost-full and both mail flags
    assign flg = {full_input_ready, empty_output_ready, almost_empty_n, almost_full_n,
                  mail1_full_n, mail2_full_n};

    // Clock and run limit
    always #50 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 10000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One bus transfer; waits for pready, takes data at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Full reset with config pins {spm, fs1, fs0, endian}; release just after a port A fall
    task automatic cfg_reset(input logic [3:0] cfg, input logic fir);
        {serial_program_mode_n, flag_sel1_serial_enable_n, flag_sel0_serial_data,
         endian_timing_select} <= cfg;
        primary_reset_n  <= 1'b0;
        mailbox2_reset_n <= 1'b0;
        repeat (40) @(negedge pclk);
        check("reset flags", flg, 6'h07);
        @(negedge port_a_clock);
        primary_reset_n  <= 1'b1;
        mailbox2_reset_n <= 1'b1;
        repeat (4) @(negedge pclk);
        check("ready early", full_input_ready, 1'b0);
        repeat (4) @(negedge pclk);
        check("ready late", full_input_ready, fir);
    endtask

    // One port A write through the far end
    task automatic write_word(input logic [9:0] d);
        @(negedge port_a_clock);
        data_a <= d;
        wr_req <= 1'b1;
        @(negedge port_a_clock);
        wr_req <= 1'b0;
        @(negedge port_a_clock);
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, wr_req, rd_req, data_a} = '0;
        {mail1_write_a, mail1_read_b, mail2_write_b, mail2_read_a} = '0;
        {partial_reset_n, serial_program_mode_n, flag_sel1_serial_enable_n} = '1;
        {primary_reset_n, mailbox2_reset_n, endian_timing_select, flag_sel0_serial_data} = '1;
        rows = '{'{4'hf, 2'h0, 1'b1, 10'h040}, '{4'hc, 2'h0, 1'b1, 10'h010},
                 '{4'hb, 2'h0, 1'b1, 10'h008}, '{4'h9, 2'h1, 1'b1, 10'h000},
                 '{4'h4, 2'h2, 1'b0, 10'h000}};
        repeat (2) @(posedge pclk);
        check("presetn flags", flg, 6'h07);
        presetn <= 1'b1;
        // Configuration table: preset, parallel and serial methods
        foreach (rows[i]) begin
            cfg_reset(rows[i].cfg, rows[i].fir);
            apb(1'b0, `FRM_OFS_STATUS, 32'h0);
            check("method", rd[7:6], rows[i].prog);
            check("endian", rd[5], rows[i].cfg[0]);
            check("timing", fall_through_mode, !rows[i].cfg[0]);
            check("long width", big_endian_b, 1'b0);
            apb(1'b0, `FRM_OFS_OFFSETS, 32'h0);
            if (rows[i].off != 10'h000)
                check("presets", rd, {6'h0, rows[i].off, 6'h0, rows[i].off});
            $display("test row %0d done", i);
        end
        // Serial load of almost-full then almost-empty offset, most significant bit first
        for (int i = 19; i >= 0; i--) begin
            @(negedge port_a_clock);
            flag_sel0_serial_data     <= ser_word[i];
            flag_sel1_serial_enable_n <= 1'b0;
        end
        @(negedge port_a_clock);
        flag_sel1_serial_enable_n <= 1'b1;
        repeat (2) @(negedge pclk);
        check("serial ready low", full_input_ready, 1'b0);
        @(posedge port_a_clock);
        repeat (2) @(negedge pclk);
        check("serial ready high", full_input_ready, 1'b1);
        apb(1'b0, `FRM_OFS_OFFSETS, 32'h0);
        check("serial offsets", rd, {6'h0, ser_word[19:10], 6'h0, ser_word[9:0]});
        apb(1'b1, `FRM_OFS_CTRL, 32'h1);
        @(negedge pclk);
        check("little endian", big_endian_b, 1'b0);
        apb(1'b1, `FRM_OFS_CTRL, 32'h0);
        $display("test serial done");
        // Parallel load, then data from the third write, endian by width, bus refusals
        cfg_reset(4'h9, 1'b1);
        write_word(10'h1f0);
        write_word(10'h00c);
        write_word(10'h155);
        repeat (40) @(posedge pclk);
        check("words present", empty_output_ready, 1'b1);
        apb(1'b0, `FRM_OFS_OFFSETS, 32'h0);
        check("parallel offsets", rd, 32'h01f0000c);
        apb(1'b0, `FRM_OFS_PTRS, 32'h0);
        check("write pointer", rd[10:0], 11'h001);
        for (int j = 1; j <= 3; j++) begin
            apb(1'b1, `FRM_OFS_CTRL, j % 3);
            @(negedge pclk);
            check("endian out", big_endian_b, j != 3);
        end
        apb(1'b1, `FRM_OFS_STATUS, 32'h0);
        apb(1'b0, `FRM_OFS_STATUS, 32'h0);
        check("status kept", rd[0], 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", err, 1'b1);
        $display("test parallel done");
        // Partial reset keeps the configuration
        partial_reset_n <= 1'b0;
        repeat (40) @(negedge pclk);
        check("partial flags", flg, 6'h07);
        @(posedge pclk);
        partial_reset_n <= 1'b1;
        repeat (20) @(negedge pclk);
        check("partial ready", full_input_ready, 1'b1);
        apb(1'b0, `FRM_OFS_PTRS, 32'h0);
        check("pointers cleared", rd, 32'h0);
        apb(1'b0, `FRM_OFS_OFFSETS, 32'h0);
        check("offsets kept", rd, 32'h01f0000c);
        apb(1'b0, `FRM_OFS_STATUS, 32'h0);
        check("method kept", rd[7:6], 2'h1);
        check("mode kept", fall_through_mode, 1'b0);
        $display("test partial reset done");
        print_verdict();
    end
endmodule
